// ---- verilog/ccx_pkg.sv ----
// Purpose: Shared constants and types for the compare/clear/complement/adjust/decrement execute block.
// Assumes: 8-bit core, opcodes as fixed by the instruction set.
// Notes:   Opcode masks select the register and pointer forms.
package ccx_pkg;
  localparam logic [7:0] OP_CMP_DIR   = 8'hB5;
  localparam logic [7:0] OP_CMP_IMM   = 8'hB4;
  localparam logic [7:0] OP_CMP_IND   = 8'hB6;
  localparam logic [7:0] OP_CMP_REG   = 8'hB8;
  localparam logic [7:0] OP_CLR_A     = 8'hE4;
  localparam logic [7:0] OP_CLR_C     = 8'hC3;
  localparam logic [7:0] OP_CLR_BIT   = 8'hC2;
  localparam logic [7:0] OP_CPL_A     = 8'hF4;
  localparam logic [7:0] OP_CPL_C     = 8'hB3;
  localparam logic [7:0] OP_CPL_BIT   = 8'hB2;
  localparam logic [7:0] OP_DA_A      = 8'hD4;
  localparam logic [7:0] OP_DEC_A     = 8'h14;
  localparam logic [7:0] OP_DEC_DIR   = 8'h15;
  localparam logic [7:0] OP_DEC_IND   = 8'h16;
  localparam logic [7:0] OP_DEC_REG   = 8'h18;
  localparam logic [7:0] MASK_REG     = 8'hF8;
  localparam logic [7:0] MASK_IND     = 8'hFE;
  localparam logic [3:0] BCD_MAX      = 4'h9;
  localparam logic [7:0] ADJ_LO       = 8'h06;
  localparam logic [8:0] ADJ_HI       = 9'h060;
  localparam logic [7:0] ONE_BYTE     = 8'h01;
  localparam logic [15:0] RESET_PC    = 16'h0000;

  typedef enum logic [1:0] {
    CCX_DST_NONE = 2'h0,
    CCX_DST_ACC  = 2'h1,
    CCX_DST_REG  = 2'h3,
    CCX_DST_MEM  = 2'h2
  } ccx_dst_t;

  typedef struct packed {
    logic        valid;
    ccx_dst_t    dst;
    logic [7:0]  data;
    logic        bit_we;
    logic        bit_val;
    logic        cy_we;
    logic        cy;
    logic        branch;
    logic [15:0] target;
  } ccx_res_t;
endpackage : ccx_pkg

// ---- verilog/ccx_if.sv ----
// Purpose: Carries a combinational result from the decoder to the registering top.
// Assumes: Single clock domain.
// Notes:   The producer drives res, the consumer samples it.
`timescale 1ns/1ps
`default_nettype none
interface ccx_if;
  ccx_pkg::ccx_res_t res;
  modport prod (output res);
  modport cons (input res);
endinterface : ccx_if
`default_nettype wire

// ---- verilog/ccx_alu.sv ----
// Purpose: Combinational decode and arithmetic for the execute group.
// Assumes: Operands already fetched; port operands come from output latches.
// Notes:   No state; the top registers the result.
`timescale 1ns/1ps
`default_nettype none
module ccx_alu (
  input  wire logic [7:0]  opcode_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  opa_i,
  input  wire logic [7:0]  opb_i,
  input  wire logic [7:0]  rel_i,
  input  wire logic        bit_i,
  input  wire logic        cy_i,
  input  wire logic        ac_i,
  input  wire logic [15:0] pc_next_i,
  input  wire logic        start_i,
  ccx_if.prod              res_if
);
  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = v - ccx_pkg::ONE_BYTE;
  endfunction : dec8

  function automatic logic is_form(input logic [7:0] op, input logic [7:0] base, input logic [7:0] mask);
    is_form = (op & mask) == base;
  endfunction : is_form

  logic [8:0] lo_sum;
  logic [8:0] hi_sum;
  logic       lo_fix;
  logic       cy_mid;
  logic       cmp_op;
  logic [7:0] cmp_a;

  always_comb begin
    res_if.res         = '0;
    res_if.res.target  = pc_next_i;
    lo_sum             = {1'b0, acc_i};
    hi_sum             = '0;
    lo_fix             = 1'b0;
    cy_mid             = cy_i;
    cmp_op             = 1'b0;
    cmp_a              = opa_i;
    res_if.res.valid   = start_i;
    case (opcode_i)
      ccx_pkg::OP_CMP_DIR, ccx_pkg::OP_CMP_IMM: begin
        cmp_op = 1'b1;
        cmp_a  = acc_i;
      end
      ccx_pkg::OP_CLR_A: begin
        res_if.res.dst  = ccx_pkg::CCX_DST_ACC;
        res_if.res.data = 8'h00;
      end
      ccx_pkg::OP_CLR_C: begin
        res_if.res.cy_we = 1'b1;
        res_if.res.cy    = 1'b0;
      end
      ccx_pkg::OP_CLR_BIT: begin
        res_if.res.bit_we  = 1'b1;
        res_if.res.bit_val = 1'b0;
      end
      ccx_pkg::OP_CPL_A: begin
        res_if.res.dst  = ccx_pkg::CCX_DST_ACC;
        res_if.res.data = ~acc_i;
      end
      ccx_pkg::OP_CPL_C: begin
        res_if.res.cy_we = 1'b1;
        res_if.res.cy    = ~cy_i;
      end
      ccx_pkg::OP_CPL_BIT: begin
        res_if.res.bit_we  = 1'b1;
        res_if.res.bit_val = ~bit_i;
      end
      ccx_pkg::OP_DA_A: begin
        lo_fix = (acc_i[3:0] > ccx_pkg::BCD_MAX) || ac_i;
        if (lo_fix) begin
          lo_sum = {1'b0, acc_i} + {1'b0, ccx_pkg::ADJ_LO};
        end
        cy_mid = cy_i | lo_sum[8];
        hi_sum = {1'b0, lo_sum[7:0]};
        if (cy_mid || (lo_sum[7:4] > ccx_pkg::BCD_MAX)) begin
          hi_sum = {1'b0, lo_sum[7:0]} + ccx_pkg::ADJ_HI;
        end
        res_if.res.dst   = ccx_pkg::CCX_DST_ACC;
        res_if.res.data  = hi_sum[7:0];
        res_if.res.cy_we = 1'b1;
        res_if.res.cy    = cy_mid | hi_sum[8];
      end
      ccx_pkg::OP_DEC_A: begin
        res_if.res.dst  = ccx_pkg::CCX_DST_ACC;
        res_if.res.data = dec8(acc_i);
      end
      ccx_pkg::OP_DEC_DIR: begin
        res_if.res.dst  = ccx_pkg::CCX_DST_MEM;
        res_if.res.data = dec8(opa_i);
      end
      default: begin
        if (is_form(opcode_i, ccx_pkg::OP_CMP_REG, ccx_pkg::MASK_REG) ||
            is_form(opcode_i, ccx_pkg::OP_CMP_IND, ccx_pkg::MASK_IND)) begin
          cmp_op = 1'b1;
        end else if (is_form(opcode_i, ccx_pkg::OP_DEC_REG, ccx_pkg::MASK_REG)) begin
          res_if.res.dst  = ccx_pkg::CCX_DST_REG;
          res_if.res.data = dec8(opa_i);
        end else if (is_form(opcode_i, ccx_pkg::OP_DEC_IND, ccx_pkg::MASK_IND)) begin
          res_if.res.dst  = ccx_pkg::CCX_DST_MEM;
          res_if.res.data = dec8(opa_i);
        end else begin
          res_if.res.valid = 1'b0;
        end
      end
    endcase
    if (cmp_op) begin
      // Operands are only read, never written back.
      res_if.res.cy_we  = 1'b1;
      res_if.res.cy     = cmp_a < opb_i;
      res_if.res.branch = cmp_a != opb_i;
      if (cmp_a != opb_i) begin
        res_if.res.target = pc_next_i + {{8{rel_i[7]}}, rel_i};
      end
    end
    if (!start_i) begin
      res_if.res = '0;
      res_if.res.target = pc_next_i;
    end
  end
endmodule : ccx_alu
`default_nettype wire

// ---- verilog/ccx_exec.sv ----
// Purpose: Execute stage for compare-branch, clear, complement, decimal adjust and decrement.
// Assumes: The fetch side supplies the opcode, operands and incremented program counter
//          together with a one-cycle start pulse; port operands are taken from output latches.
// Notes:   Results appear one cycle after start; done and the write strobes last one cycle, while data, bit, carry and pc stand until the next start.
// Functional notes
// - Branch to next PC plus displacement when unequal.
// - Carry set when first below second unsigned.
// - Four compare forms, register form masked.
// - Clear accumulator, flags untouched.
// - Clear carry or addressed bit only.
// - Complement accumulator, flags untouched.
// - Complement carry or addressed bit only.
// - Port read-modify-write uses output latch value.
// - Low nibble add six, carry only set.
// - High nibble add six, carry only set.
// - Decimal adjust completes in one cycle.
// - Decrement wraps zero to all ones.
// - Decrement forms: accumulator, register, direct, indirect.
`timescale 1ns/1ps
`default_nettype none
module ccx_exec (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  opa_i,
  input  wire logic [7:0]  opb_i,
  input  wire logic [7:0]  rel_i,
  input  wire logic        bit_i,
  input  wire logic        cy_i,
  input  wire logic        aux_carry_flag_i,
  input  wire logic [15:0] pc_next_i,
  output logic             done_o,
  output logic             acc_we_o,
  output logic             reg_we_o,
  output logic             mem_we_o,
  output logic [7:0]       data_o,
  output logic             bit_we_o,
  output logic             bit_o,
  output logic             cy_we_o,
  output logic             cy_o,
  output logic             branch_o,
  output logic [15:0]      pc_o
);
  typedef struct packed {
    ccx_pkg::ccx_res_t res;
  } ccx_state_t;

  ccx_state_t state_q;
  ccx_state_t state_d;
  ccx_if      res_bus ();

  ccx_alu u_alu (
    .opcode_i  (opcode_i),
    .acc_i     (acc_i),
    .opa_i     (opa_i),
    .opb_i     (opb_i),
    .rel_i     (rel_i),
    .bit_i     (bit_i),
    .cy_i      (cy_i),
    .ac_i      (aux_carry_flag_i),
    .pc_next_i (pc_next_i),
    .start_i   (start_i),
    .res_if    (res_bus.prod)
  );

  // Result values are held between starts so the core may sample them late; valid lasts one cycle.
  always_comb begin
    state_d = state_q;
    state_d.res.valid = 1'b0;
    if (start_i) begin
      state_d.res = res_bus.res;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q            <= '0;
      state_q.res.target <= ccx_pkg::RESET_PC;
    end else begin
      state_q <= state_d;
    end
  end

  assign done_o   = state_q.res.valid;
  assign acc_we_o = state_q.res.valid && (state_q.res.dst == ccx_pkg::CCX_DST_ACC);
  assign reg_we_o = state_q.res.valid && (state_q.res.dst == ccx_pkg::CCX_DST_REG);
  assign mem_we_o = state_q.res.valid && (state_q.res.dst == ccx_pkg::CCX_DST_MEM);
  assign data_o   = state_q.res.data;
  assign bit_we_o = state_q.res.valid && state_q.res.bit_we;
  assign bit_o    = state_q.res.bit_val;
  assign cy_we_o  = state_q.res.valid && state_q.res.cy_we;
  assign cy_o     = state_q.res.cy;
  assign branch_o = state_q.res.valid && state_q.res.branch;
  assign pc_o     = state_q.res.target;
endmodule : ccx_exec
`default_nettype wire

// ---- sim/ccx_exec_properties.sv ----
// Purpose: Port-level properties of the execute block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound onto every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module ccx_exec_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        start_i,
  input wire logic [7:0]  opcode_i,
  input wire logic [7:0]  acc_i,
  input wire logic [7:0]  opa_i,
  input wire logic [7:0]  opb_i,
  input wire logic [7:0]  rel_i,
  input wire logic        bit_i,
  input wire logic        cy_i,
  input wire logic [15:0] pc_next_i,
  input wire logic        done_o,
  input wire logic        acc_we_o,
  input wire logic [7:0]  data_o,
  input wire logic        bit_we_o,
  input wire logic        bit_o,
  input wire logic        cy_we_o,
  input wire logic        cy_o,
  input wire logic        branch_o,
  input wire logic [15:0] pc_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic        cmp;
  logic        lt;
  logic [7:0]  fst;
  logic [15:0] tgt;
  assign cmp = start_i && ((opcode_i & 8'hFC) == 8'hB4 || (opcode_i & ccx_pkg::MASK_REG) == ccx_pkg::OP_CMP_REG);
  // Only the two accumulator forms compare the accumulator; all others compare the fetched operand.
  assign fst = (opcode_i[3:1] == 3'h2) ? acc_i : opa_i;
  assign lt  = fst < opb_i;
  assign tgt = pc_next_i + {{8{rel_i[7]}}, rel_i};
  sequence s_take; start_i && opcode_i == ccx_pkg::OP_CLR_A; endsequence
  sequence s_pulse; done_o ##1 !done_o; endsequence
  property p_branch; cmp && fst != opb_i |=> branch_o && pc_o == $past(tgt); endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");
  property p_cmp_cy; cmp |=> cy_we_o && cy_o == $past(lt) && !acc_we_o; endproperty
  a_cmp_cy: assert property (p_cmp_cy) else $error("compare carry wrong");
  property p_equal; cmp && fst == opb_i |=> !branch_o && pc_o == $past(pc_next_i); endproperty
  a_equal: assert property (p_equal) else $error("equal compare branched");
  property p_clr_a; s_take |=> acc_we_o && data_o == 8'h00 && !cy_we_o; endproperty
  a_clr_a: assert property (p_clr_a) else $error("clear accumulator wrong");
  property p_cpl_a; start_i && opcode_i == ccx_pkg::OP_CPL_A |=> data_o == ~$past(acc_i) && !cy_we_o; endproperty
  a_cpl_a: assert property (p_cpl_a) else $error("complement accumulator wrong");
  property p_cpl_bit; start_i && opcode_i == ccx_pkg::OP_CPL_BIT |=> bit_we_o && bit_o != $past(bit_i); endproperty
  a_cpl_bit: assert property (p_cpl_bit) else $error("complement bit wrong");
  property p_dec_a; start_i && opcode_i == ccx_pkg::OP_DEC_A |=> data_o == $past(acc_i) - 8'h01 && !cy_we_o; endproperty
  a_dec_a: assert property (p_dec_a) else $error("decrement wrong");
  property p_da_cy; start_i && opcode_i == ccx_pkg::OP_DA_A && cy_i |=> cy_we_o && cy_o; endproperty
  a_da_cy: assert property (p_da_cy) else $error("adjust cleared carry");
  property p_done_pulse; s_take ##1 !start_i |-> s_pulse; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
endmodule : ccx_exec_chk
bind ccx_exec ccx_exec_chk ccx_exec_chk_inst (.ref_clk_i, .rst_i, .start_i, .opcode_i, .acc_i, .opa_i, .opb_i,
  .rel_i, .bit_i, .cy_i, .pc_next_i, .done_o, .acc_we_o, .data_o, .bit_we_o, .bit_o, .cy_we_o, .cy_o, .branch_o, .pc_o);
`default_nettype wire

// ---- sim/cmp_clr_cpl_da_dec_execute_test.sv ----
// Purpose: Self-checking bench for the execute block.
// Assumes: 50 MHz clock, inputs driven 1 ns after each rising edge.
// Notes:   Rows run back to back, one start per cycle.
`timescale 1ns/1ps
`default_nettype none
module cmp_clr_cpl_da_dec_execute_test;
  logic        clk, rst, start, cy, ac, bt;
  logic [7:0]  op, acc, opa, opb, rel;
  logic [15:0] pcn;
  logic        done_o, acc_we_o, reg_we_o, mem_we_o, bit_we_o, bit_o, cy_we_o, cy_o, branch_o;
  logic [7:0]  data_o;
  logic [15:0] pc_o;
  int          miscompares, cmp_count, cyc;
  // Row: opcode, acc, opa, opb, {c,aux,bit}, strobes {acc,reg,mem,bit,cy,br}, data, flag.
  logic [55:0] rows [18] = '{
    56'hB4340056_0_03_00_1, 56'hB5560056_0_02_00_0, 56'hBB00605F_0_03_00_0, 56'hB70000FF_0_03_00_1,
    56'hC3000000_4_02_00_0, 56'hC2000000_1_04_00_0, 56'hF45C0000_0_20_A3_0, 56'hB3000000_0_02_00_1,
    56'hB2000000_1_04_00_0, 56'hD4BE0000_0_22_24_1, 56'hD4C90000_0_22_29_1, 56'hD4190000_2_22_1F_0,
    56'hD4000000_4_22_60_1, 56'h14000000_0_20_FF_0, 56'h15004000_0_08_3F_0, 56'h17008000_0_08_7F_0,
    56'h1F000000_0_10_FF_0, 56'hE45C0000_0_20_00_0};
  ccx_exec ccx_exec_inst (.ref_clk_i(clk), .rst_i(rst), .start_i(start), .opcode_i(op), .acc_i(acc), .opa_i(opa),
    .opb_i(opb), .rel_i(rel), .bit_i(bt), .cy_i(cy), .aux_carry_flag_i(ac), .pc_next_i(pcn), .done_o, .acc_we_o,
    .reg_we_o, .mem_we_o, .data_o, .bit_we_o, .bit_o, .cy_we_o, .cy_o, .branch_o, .pc_o);
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic drive(input logic [55:0] r);
    {op, acc, opa, opb} = r[55:24];
    {cy, ac, bt} = r[22:20];
    start = 1'b1;
  endtask : drive
  task automatic check(input logic [55:0] r);
    chk("done", 16'(done_o), 16'h0001);
    chk("strobes", 16'({acc_we_o, reg_we_o, mem_we_o, bit_we_o, cy_we_o, branch_o}), 16'(r[17:12]));
    if (r[17:15] != 3'h0) chk("data", 16'(data_o), 16'(r[11:4]));
    if (r[13]) chk("carry", 16'(cy_o), 16'(r[0]));
    if (r[14]) chk("bit", 16'(bit_o), 16'(r[0]));
    chk("pc", pc_o, r[12] ? pcn + {{8{rel[7]}}, rel} : pcn);
  endtask : check
  task automatic reset_check();
    chk("reset flags", 16'({done_o, acc_we_o, reg_we_o, mem_we_o, bit_we_o, bit_o, cy_we_o, cy_o, branch_o}), 16'h0000);
    chk("reset words", pc_o | 16'(data_o), 16'h0000);
  endtask : reset_check
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run is about 30 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    {start, op, acc, opa, opb, cy, ac, bt} = '0;
    rel = 8'hFE;
    pcn = 16'h0103;
    rst = 1'b1;
    repeat (6) step();
    reset_check();
    $display("power-on reset done");
    rst = 1'b0;
    for (int i = 0; i <= 18; i++) begin
      step();
      if (i > 0) check(rows[i-1]);
      if (i < 18) drive(rows[i]);
      else start = 1'b0;
    end
    step();
    chk("done idle", 16'(done_o), 16'h0000);
    $display("row table done");
    rel = 8'h7F;
    drive(56'hB4000001_0_03_00_1);
    step();
    check(56'hB4000001_0_03_00_1);
    $display("forward branch done");
    drive(rows[6]);
    rst = 1'b1;
    step();
    reset_check();
    {rst, start} = 2'h0;
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule : cmp_clr_cpl_da_dec_execute_test
`default_nettype wire
